// ===== gpp_pkg.sv
`default_nettype none

package gpp_pkg;

  // port geometry
  localparam int NPIN = 8;
  localparam int OE_LINES = 16;
  localparam int OE_SEL_W = 4;
  localparam int PSEL_W = 4;

  // drive modes of the 3-bit per-pin field
  typedef enum logic [2:0] {
    DM_HIZ_ANA,
    DM_HIZ_DIG,
    DM_RES_PU,
    DM_RES_PD,
    DM_OD_LO,
    DM_OD_HI,
    DM_STRONG,
    DM_RES_PUPD
  } gpp_dm_t;

  // per-pin edge selection; no level option exists
  typedef enum logic [1:0] {
    IRQ_NONE,
    IRQ_RISE,
    IRQ_FALL,
    IRQ_BOTH
  } gpp_irq_t;

  // the pin-form byte: the eight most-used bits of one pin
  typedef struct packed {
    gpp_irq_t irq;
    logic slow;
    logic ibuf_dis;
    gpp_dm_t dm;
    logic dout;
  } gpp_pin_byte_t;

  // full per-pin configuration
  typedef struct packed {
    logic bidir_en;
    logic [OE_SEL_W-1:0] oe_sel;
    gpp_pin_byte_t b;
  } gpp_pin_cfg_t;

  // pad drive controls of one pin
  typedef struct packed {
    logic out;
    logic oe;
    logic pu;
    logic pd;
    logic slow;
  } gpp_drv_t;

  // port-form register selects, one bit per pin in each except PSEL_THRESH, whose single bit serves the whole port
  localparam logic [PSEL_W-1:0] PSEL_DOUT = 4'h0;
  localparam logic [PSEL_W-1:0] PSEL_DM0 = 4'h1;
  localparam logic [PSEL_W-1:0] PSEL_DM1 = 4'h2;
  localparam logic [PSEL_W-1:0] PSEL_DM2 = 4'h3;
  localparam logic [PSEL_W-1:0] PSEL_SLEW = 4'h4;
  localparam logic [PSEL_W-1:0] PSEL_IBUF_DIS = 4'h5;
  localparam logic [PSEL_W-1:0] PSEL_BIDIR = 4'h6;
  localparam logic [PSEL_W-1:0] PSEL_IRQ0 = 4'h7;
  localparam logic [PSEL_W-1:0] PSEL_IRQ1 = 4'h8;
  localparam logic [PSEL_W-1:0] PSEL_OESEL0 = 4'h9;
  localparam logic [PSEL_W-1:0] PSEL_OESEL1 = 4'hA;
  localparam logic [PSEL_W-1:0] PSEL_OESEL2 = 4'hB;
  localparam logic [PSEL_W-1:0] PSEL_OESEL3 = 4'hC;
  localparam logic [PSEL_W-1:0] PSEL_THRESH = 4'hD;
  localparam logic [PSEL_W-1:0] PSEL_STATE = 4'hE;

  // reset values
  localparam gpp_pin_cfg_t RST_PIN_CFG = '{
    bidir_en: 1'b0,
    oe_sel: 4'h0,
    b: '{irq: IRQ_NONE, slow: 1'b0, ibuf_dis: 1'b0,
         dm: DM_HIZ_DIG, dout: 1'b0}
  };
  localparam logic RST_THRESH = 1'b0;
  localparam logic [NPIN-1:0] RST_BYTE = 8'h00;

endpackage

`default_nettype wire

// ===== gpp_port.sv
`timescale 1ns/1ps
`default_nettype none

module gpp_port (
  input wire logic clk,
  input wire logic reset,
  input wire logic port_wr,
  input wire logic [gpp_pkg::PSEL_W-1:0] port_sel,
  input wire logic [gpp_pkg::NPIN-1:0] port_wdata,
  output logic [gpp_pkg::NPIN-1:0] port_rdata,
  input wire logic pin_wr,
  input wire logic [2:0] pin_idx,
  input wire gpp_pkg::gpp_pin_byte_t pin_wdata,
  output gpp_pkg::gpp_pin_byte_t pin_rdata,
  input wire logic status_rd,
  output logic [gpp_pkg::NPIN-1:0] status_rdata,
  output logic irq,
  input wire logic [gpp_pkg::OE_LINES-1:0] aux_oe,
  input wire logic [gpp_pkg::NPIN-1:0] pin_in,
  output logic [gpp_pkg::NPIN-1:0] pin_out,
  output logic [gpp_pkg::NPIN-1:0] pin_oe,
  output logic [gpp_pkg::NPIN-1:0] pin_pu_en,
  output logic [gpp_pkg::NPIN-1:0] pin_pd_en,
  output logic [gpp_pkg::NPIN-1:0] pin_slow,
  output logic [gpp_pkg::NPIN-1:0] pin_ibuf_en,
  output logic thresh_lvttl
);
  import gpp_pkg::*;

  gpp_pin_cfg_t cfg_r [NPIN];
  logic thresh_r;
  logic [NPIN-1:0] sync1_r;
  logic [NPIN-1:0] sync2_r;
  logic [NPIN-1:0] prev_r;
  logic [NPIN-1:0] din;
  logic [NPIN-1:0] rise;
  logic [NPIN-1:0] fall;
  logic [NPIN-1:0] evt;
  logic [NPIN-1:0] status_r;
  logic [NPIN-1:0] status_nxt;
  logic [NPIN-1:0] status_clr;
  logic [NPIN-1:0] port_byte;
  gpp_dm_t dm_eff [NPIN];
  gpp_drv_t drv_nxt [NPIN];

  // read one port-form bit of a pin
  function automatic logic port_bit(gpp_pin_cfg_t c,
                                    logic [PSEL_W-1:0] s);
    logic v = 1'b0;
    unique case (s)
      PSEL_DOUT: v = c.b.dout;
      PSEL_DM0: v = c.b.dm[0];
      PSEL_DM1: v = c.b.dm[1];
      PSEL_DM2: v = c.b.dm[2];
      PSEL_SLEW: v = c.b.slow;
      PSEL_IBUF_DIS: v = c.b.ibuf_dis;
      PSEL_BIDIR: v = c.bidir_en;
      PSEL_IRQ0: v = c.b.irq[0];
      PSEL_IRQ1: v = c.b.irq[1];
      PSEL_OESEL0: v = c.oe_sel[0];
      PSEL_OESEL1: v = c.oe_sel[1];
      PSEL_OESEL2: v = c.oe_sel[2];
      PSEL_OESEL3: v = c.oe_sel[3];
      default: v = 1'b0;
    endcase
    return v;
  endfunction

  // update one port-form bit of a pin
  function automatic gpp_pin_cfg_t set_bit(gpp_pin_cfg_t c,
                                           logic [PSEL_W-1:0] s,
                                           logic v);
    gpp_pin_cfg_t r = c;
    unique case (s)
      PSEL_DOUT: r.b.dout = v;
      PSEL_DM0: r.b.dm = gpp_dm_t'({c.b.dm[2:1], v});
      PSEL_DM1: r.b.dm = gpp_dm_t'({c.b.dm[2], v, c.b.dm[0]});
      PSEL_DM2: r.b.dm = gpp_dm_t'({v, c.b.dm[1:0]});
      PSEL_SLEW: r.b.slow = v;
      PSEL_IBUF_DIS: r.b.ibuf_dis = v;
      PSEL_BIDIR: r.bidir_en = v;
      PSEL_IRQ0: r.b.irq = gpp_irq_t'({c.b.irq[1], v});
      PSEL_IRQ1: r.b.irq = gpp_irq_t'({v, c.b.irq[0]});
      PSEL_OESEL0: r.oe_sel[0] = v;
      PSEL_OESEL1: r.oe_sel[1] = v;
      PSEL_OESEL2: r.oe_sel[2] = v;
      PSEL_OESEL3: r.oe_sel[3] = v;
      default: r = c;
    endcase
    return r;
  endfunction

  // pin form first: a pin-form write to a pin drops that pin's port-form write of the same cycle
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < NPIN; i++)
    begin
      if (reset)
        cfg_r[i] <= RST_PIN_CFG;
      else if (pin_wr && pin_idx == i[2:0])
        cfg_r[i].b <= pin_wdata;
      else if (port_wr)
        cfg_r[i] <= set_bit(cfg_r[i], port_sel, port_wdata[i]);
    end
  end

  // one threshold for the whole port
  always_ff @(posedge clk)
  begin
    if (reset)
      thresh_r <= RST_THRESH;
    else if (port_wr && port_sel == PSEL_THRESH)
      thresh_r <= port_wdata[0];
  end

  // port-form read view, registered
  always_comb
  begin
    port_byte = RST_BYTE;
    for (int i = 0; i < NPIN; i++)
      port_byte[i] = port_bit(cfg_r[i], port_sel);
    if (port_sel == PSEL_THRESH)
      port_byte = {7'h00, thresh_r};
    else if (port_sel == PSEL_STATE)
      port_byte = din;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      port_rdata <= RST_BYTE;
      pin_rdata <= RST_PIN_CFG.b;
    end
    else
    begin
      port_rdata <= port_byte;
      pin_rdata <= cfg_r[pin_idx].b;
    end
  end

  // aux enable low forces hi-z digital, high restores the chosen mode
  always_comb
  begin
    for (int i = 0; i < NPIN; i++)
    begin
      dm_eff[i] = cfg_r[i].b.dm;
      if (cfg_r[i].bidir_en && !aux_oe[cfg_r[i].oe_sel])
        dm_eff[i] = DM_HIZ_DIG;
    end
  end

  // pad controls per drive mode; slew matters only for hard drive
  always_comb
  begin
    for (int i = 0; i < NPIN; i++)
    begin
      drv_nxt[i] = '0;
      drv_nxt[i].out = cfg_r[i].b.dout;
      unique case (dm_eff[i])
        DM_HIZ_ANA, DM_HIZ_DIG: drv_nxt[i].out = 1'b0;
        DM_RES_PU:
        begin
          drv_nxt[i].pu = cfg_r[i].b.dout;
          drv_nxt[i].oe = !cfg_r[i].b.dout;
        end
        DM_RES_PD:
        begin
          drv_nxt[i].pd = !cfg_r[i].b.dout;
          drv_nxt[i].oe = cfg_r[i].b.dout;
        end
        DM_OD_LO: drv_nxt[i].oe = !cfg_r[i].b.dout;
        DM_OD_HI: drv_nxt[i].oe = cfg_r[i].b.dout;
        DM_STRONG: drv_nxt[i].oe = 1'b1;
        DM_RES_PUPD:
        begin
          drv_nxt[i].pu = cfg_r[i].b.dout;
          drv_nxt[i].pd = !cfg_r[i].b.dout;
        end
      endcase
      drv_nxt[i].slow = cfg_r[i].b.slow &&
        (dm_eff[i] inside {DM_OD_LO, DM_OD_HI, DM_STRONG});
    end
  end

  // pad outputs straight from flops; reset parks every pad released
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < NPIN; i++)
    begin
      pin_out[i] <= drv_nxt[i].out && !reset;
      pin_oe[i] <= drv_nxt[i].oe && !reset;
      pin_pu_en[i] <= drv_nxt[i].pu && !reset;
      pin_pd_en[i] <= drv_nxt[i].pd && !reset;
      pin_slow[i] <= drv_nxt[i].slow && !reset;
    end
  end

  // buffer enables and threshold registered toward the pads
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pin_ibuf_en <= ~RST_BYTE;
      thresh_lvttl <= RST_THRESH;
    end
    else
    begin
      for (int i = 0; i < NPIN; i++)
        pin_ibuf_en[i] <= !cfg_r[i].b.ibuf_dis;
      thresh_lvttl <= thresh_r;
    end
  end

  // two-flop synchroniser; the first stage feeds only the second
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      sync1_r <= RST_BYTE;
      sync2_r <= RST_BYTE;
      prev_r <= RST_BYTE;
    end
    else
    begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
      prev_r <= din;
    end
  end

  // pure edge detect: no clock gating here, so sleep never stops it
  always_comb
  begin
    for (int i = 0; i < NPIN; i++)
    begin
      din[i] = sync2_r[i] && !cfg_r[i].b.ibuf_dis;
      rise[i] = din[i] && !prev_r[i];
      fall[i] = !din[i] && prev_r[i];
      unique case (cfg_r[i].b.irq)
        IRQ_NONE: evt[i] = 1'b0;
        IRQ_RISE: evt[i] = rise[i];
        IRQ_FALL: evt[i] = fall[i];
        IRQ_BOTH: evt[i] = rise[i] || fall[i];
      endcase
    end
  end

  // a new event wins over the clear of the same cycle
  always_comb
  begin
    status_clr = status_rd ? status_r : RST_BYTE;
    status_nxt = (status_r & ~status_clr) | evt;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      status_r <= RST_BYTE;
      status_rdata <= RST_BYTE;
      irq <= 1'b0;
    end
    else
    begin
      status_r <= status_nxt;
      if (status_rd)
        status_rdata <= status_r;
      irq <= |status_nxt;
    end
  end

  // checks, per pin, then for the whole port
  for (genvar g = 0; g < NPIN; g++)
  begin : g_chk
    a_od_low_only:
    assert property (@(posedge clk) disable iff (reset)
      $past(dm_eff[g] == DM_OD_LO) |-> !(pin_oe[g] && pin_out[g]))
      else $error("open drain low drove high");

    a_res_single_mode:
    assert property (@(posedge clk) disable iff (reset)
      $past(dm_eff[g] == DM_RES_PU) |->
        (pin_pu_en[g] != pin_oe[g]) && pin_pu_en[g] == $past(cfg_r[g].b.dout))
      else $error("pull-up mode drive wrong");

    a_res_both_mode:
    assert property (@(posedge clk) disable iff (reset)
      $past(dm_eff[g] == DM_RES_PUPD) |-> !pin_oe[g] &&
        pin_pu_en[g] == $past(cfg_r[g].b.dout) &&
        pin_pd_en[g] == !$past(cfg_r[g].b.dout))
      else $error("combined resistive drive wrong");

    a_strong_follows:
    assert property (@(posedge clk) disable iff (reset)
      $past(dm_eff[g] == DM_STRONG) |->
        pin_oe[g] && pin_out[g] == $past(cfg_r[g].b.dout))
      else $error("strong drive not following data");

    a_bidir_hiz:
    assert property (@(posedge clk) disable iff (reset)
      cfg_r[g].bidir_en && !aux_oe[cfg_r[g].oe_sel] |=>
        !pin_oe[g] && !pin_pu_en[g] && !pin_pd_en[g])
      else $error("aux enable low but pin driven");

    a_slew_hard_only:
    assert property (@(posedge clk) disable iff (reset)
      pin_slow[g] |-> $past(cfg_r[g].b.slow) &&
        $past(dm_eff[g] inside {DM_OD_LO, DM_OD_HI, DM_STRONG}))
      else $error("slow slew in resistive mode");

    a_sync_delay:
    assert property (@(posedge clk) disable iff (reset)
      $rose(pin_in[g]) |-> ##2 sync2_r[g])
      else $error("synchroniser latency wrong");

    a_edge_sets_status:
    assert property (@(posedge clk) disable iff (reset)
      evt[g] |=> status_r[g] && irq)
      else $error("event did not set status and request");
  end

  a_read_clears:
  assert property (@(posedge clk) disable iff (reset)
    status_rd && evt == '0 |=> status_r == '0 ##0 !irq)
    else $error("status read did not clear");

  a_irq_held:
  assert property (@(posedge clk) disable iff (reset)
    status_r != '0 && !status_rd |=> irq)
    else $error("request dropped with status set");

  c_rise_event:
  cover property (@(posedge clk) disable iff (reset)
    rise[1] && cfg_r[1].b.irq == IRQ_RISE ##1 status_r[1]);
  c_both_fall:
  cover property (@(posedge clk) disable iff (reset)
    fall[3] && cfg_r[3].b.irq == IRQ_BOTH);
  c_bidir_switch:
  cover property (@(posedge clk) disable iff (reset)
    cfg_r[2].bidir_en && pin_oe[2] ##1 !pin_oe[2]);
  c_irq_cleared:
  cover property (@(posedge clk) disable iff (reset)
    irq ##1 status_rd ##1 !irq);

endmodule

`default_nettype wire

// ===== gpp_pad_model.sv
`timescale 1ns/1ps
`default_nettype none

module gpp_pad_model (
  input wire logic clk,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_pu_en,
  input wire logic [7:0] pin_pd_en,
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  output logic [7:0] pin_in
);
  logic [7:0] last_r = 8'h00;

  // wire level: strong driver, then outside driver, then resistors
  // a floating pin flips each cycle so it never reads as a clean level
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (pin_oe[i])
        pin_in[i] = pin_out[i];
      else if (ext_en[i])
        pin_in[i] = ext_val[i];
      else if (pin_pu_en[i])
        pin_in[i] = 1'b1;
      else if (pin_pd_en[i])
        pin_in[i] = 1'b0;
      else
        pin_in[i] = ~last_r[i];
    end
  end

  // remembers the level for the floating pattern
  always_ff @(posedge clk)
    last_r <= pin_in;
endmodule

`default_nettype wire

// ===== gpp_port_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) \
  begin \
    checks_done++; \
    if ((g) !== (e)) \
    begin \
      miscompares++; \
      $display("[FAIL] %0t got %h exp %h", $time, g, e); \
    end \
  end

module gpp_port_tb_top;
  import gpp_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic port_wr = 1'b0;
  logic [PSEL_W-1:0] port_sel = PSEL_DOUT;
  logic [NPIN-1:0] port_wdata = 8'h00;
  logic pin_wr = 1'b0;
  logic [2:0] pin_idx = 3'h0;
  gpp_pin_byte_t pin_wdata = '0;
  logic status_rd = 1'b0;
  logic [OE_LINES-1:0] aux_oe = 16'h0000;
  logic [7:0] ext_en = 8'h00;
  logic [7:0] ext_val = 8'h00;
  logic [7:0] port_rdata, status_rdata, pin_out, pin_oe, pin_pu_en;
  logic [7:0] pin_pd_en, pin_slow, pin_ibuf_en, pin_in;
  gpp_pin_byte_t pin_rdata, rb;
  logic irq, thresh_lvttl;
  int miscompares = 0;
  int checks_done = 0;
  integer seed = 32'hf6236317;
  logic [11:0] exp_q[$];
  logic [11:0] note;
  logic [2:0] ri;
  gpp_drv_t e;

  initial forever #20 clk = ~clk;

  gpp_port u_gpp_port (.clk(clk), .reset(reset), .port_wr(port_wr),
    .port_sel(port_sel), .port_wdata(port_wdata), .port_rdata(port_rdata),
    .pin_wr(pin_wr), .pin_idx(pin_idx), .pin_wdata(pin_wdata),
    .pin_rdata(pin_rdata), .status_rd(status_rd),
    .status_rdata(status_rdata), .irq(irq), .aux_oe(aux_oe),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pu_en(pin_pu_en), .pin_pd_en(pin_pd_en), .pin_slow(pin_slow),
    .pin_ibuf_en(pin_ibuf_en), .thresh_lvttl(thresh_lvttl));

  gpp_pad_model u_gpp_pad_model (.clk(clk), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_pu_en(pin_pu_en), .pin_pd_en(pin_pd_en),
    .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

  // pad controls that one pin should show for a mode and data value
  function automatic gpp_drv_t exp_drv(input logic [2:0] m, input logic d);
    exp_drv = '0;
    exp_drv.out = (m > 3'd1) ? d : 1'b0;
    exp_drv.pu = (m == 3'd2 || m == 3'd7) && d;
    exp_drv.pd = (m == 3'd3 || m == 3'd7) && !d;
    exp_drv.oe = (m == 3'd2 && !d) || (m == 3'd3 && d) ||
      (m == 3'd4 && !d) || (m == 3'd5 && d) || m == 3'd6;
    exp_drv.slow = m >= 3'd4 && m <= 3'd6;
  endfunction

  // output picked by a note code
  function automatic logic [7:0] got(input logic [3:0] c);
    case (c)
      4'h0: got = pin_out;
      4'h1: got = pin_oe;
      4'h2: got = pin_pu_en;
      4'h3: got = pin_pd_en;
      4'h4: got = pin_slow;
      4'h5: got = pin_ibuf_en;
      4'h6: got = port_rdata;
      4'h7: got = pin_rdata;
      4'h8: got = status_rdata;
      4'h9: got = {7'h00, irq};
      default: got = {7'h00, thresh_lvttl};
    endcase
  endfunction

  task automatic expect_v(input logic [3:0] c, input logic [7:0] v);
    exp_q.push_back({c, v});
  endtask

  task automatic wr(input logic [3:0] s, input logic [7:0] d);
    @(posedge clk);
    port_wr <= 1'b1;
    port_sel <= s;
    port_wdata <= d;
    @(posedge clk);
    port_wr <= 1'b0;
  endtask

  // generous wait; covers the two-flop input path too
  task automatic settle();
    repeat (5) @(posedge clk);
  endtask

  task automatic rdp(input logic [3:0] s, input logic [7:0] v);
    @(posedge clk);
    port_sel <= s;
    repeat (2) @(posedge clk);
    expect_v(4'h6, v);
  endtask

  task automatic rd_status();
    @(posedge clk);
    status_rd <= 1'b1;
    @(posedge clk);
    status_rd <= 1'b0;
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // compares each note at the falling edge after it was queued
  always @(negedge clk)
  begin
    while (exp_q.size() > 0)
    begin
      note = exp_q.pop_front();
      `CHK(got(note[11:8]), note[7:0])
    end
  end

  // watchdog, well beyond the few hundred cycles the run needs
  initial
  begin
    repeat (4000) @(posedge clk);
    miscompares++;
    end_of_test();
  end

  // main sequence
  initial
  begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    expect_v(4'h5, 8'hFF);
    expect_v(4'h7, 8'h02);
    expect_v(4'h9, 8'h00);
    wr(PSEL_THRESH, 8'h01);
    settle();
    expect_v(4'hA, 8'h01);
    rdp(PSEL_THRESH, 8'h01);
    rdp(4'hF, 8'h00);
    wr(PSEL_IBUF_DIS, 8'h10);
    settle();
    expect_v(4'h5, 8'hEF);
    // slow edges everywhere, as for signals below 1 MHz
    wr(PSEL_SLEW, 8'hFF);
    for (int m = 0; m < 8; m++)
    begin
      for (int d = 0; d < 2; d++)
      begin
        wr(PSEL_DM0, {8{m[0]}});
        wr(PSEL_DM1, {8{m[1]}});
        wr(PSEL_DM2, {8{m[2]}});
        wr(PSEL_DOUT, {8{d[0]}});
        settle();
        e = exp_drv(m[2:0], d[0]);
        expect_v(4'h0, {8{e.out}});
        expect_v(4'h1, {8{e.oe}});
        expect_v(4'h2, {8{e.pu}});
        expect_v(4'h3, {8{e.pd}});
        expect_v(4'h4, {8{e.slow}});
        rdp(PSEL_DM2, {8{m[2]}});
      end
    end
    // strong, high, pins 2 and 6 follow aux line 5
    wr(PSEL_DM0, 8'h00);
    wr(PSEL_BIDIR, 8'h44);
    wr(PSEL_OESEL0, 8'h44);
    wr(PSEL_OESEL2, 8'h44);
    @(posedge clk);
    aux_oe <= 16'($random(seed)) | 16'h0020;
    settle();
    expect_v(4'h1, 8'hFF);
    aux_oe <= aux_oe & 16'hFFDF;
    settle();
    expect_v(4'h1, 8'hBB);
    expect_v(4'h0, 8'hBB);
    // pin form write of a random byte to a random pin
    ri = 3'($random(seed));
    rb = gpp_pin_byte_t'(8'($random(seed)));
    pin_wr <= 1'b1;
    pin_idx <= ri;
    pin_wdata <= rb;
    @(posedge clk);
    pin_wr <= 1'b0;
    @(posedge clk);
    expect_v(4'h7, rb);
    rdp(PSEL_DM0, 8'(rb.dm[0]) << ri);
    rdp(PSEL_DOUT, ~(8'(!rb.dout) << ri));
    // digital hi-z before any outside drive
    wr(PSEL_DM0, 8'hFF);
    wr(PSEL_DM1, 8'h00);
    wr(PSEL_DM2, 8'h00);
    wr(PSEL_BIDIR, 8'h00);
    ext_en <= 8'hFF;
    wr(PSEL_IBUF_DIS, 8'h80);
    wr(PSEL_IRQ0, 8'hAA);
    wr(PSEL_IRQ1, 8'hCC);
    settle();
    rd_status();
    ext_val <= 8'hFF;
    settle();
    expect_v(4'h9, 8'h01);
    settle();
    expect_v(4'h9, 8'h01);
    rdp(PSEL_STATE, 8'h7F);
    rd_status();
    expect_v(4'h8, 8'h2A);
    expect_v(4'h9, 8'h00);
    settle();
    expect_v(4'h9, 8'h00);
    ext_val <= 8'h00;
    settle();
    expect_v(4'h9, 8'h01);
    rd_status();
    expect_v(4'h8, 8'h4C);
    repeat (2) @(posedge clk);
    end_of_test();
  end
endmodule

`default_nettype wire
